// File: core/spr_port.sv
// Core-side scratchpad port logic for the instruction and data sides.
`timescale 1ns/1ns
`default_nettype none
`include "spr_cfg.svh"

////////////////////////////////////////////////////////////////////////////
// Functional notes
// - Tag read word is address bits 31..10, lock, valid; loads holding reg.
// - Stall marks an unfinished read; results are used only after it drops.
// - Instruction side drives one index, address bits 19..2, for all.
// - Instruction read strobe reads tag and data; hit and stall follow it.
// - Tag write strobe tells the memory to update its stored tag.
// - On an instruction data write the shared bus carries the data word.
// - On a tag write the bus is eight zeros then holding register bits.
// - Compare word is zeros, address bits 31..10, uncacheable, zero.
// - Uncacheable bit is high for an uncacheable address, else low.
// - Data write strobe stores the bus value at the presented index.
// - Data side compare is address bits plus two zeros; writes use tag.
// - Data side gives four byte enables with every data write.
// - Reads may stall for cycles; memory answers in the strobe's own cycle.
module spr_port
  import spr_pkg::*;
(
  input  wire logic                    ref_clk_in,
  input  wire logic                    reset_in,
  // Requests from the pipeline and their answers.
  input  wire spr_req_t                iside_req_in,
  input  wire spr_req_t                dside_req_in,
  output logic                         iside_ready_out,
  output logic                         dside_ready_out,
  output spr_rsp_t                     iside_rsp_out,
  output spr_rsp_t                     dside_rsp_out,
  output logic [`SPR_TAG_W-1:0]        iside_tag_holding_register_out,
  output logic [`SPR_TAG_W-1:0]        dside_tag_holding_register_out,
  // Instruction-side memory pins.
  output logic [`SPR_IDX_W-1:0]        iside_index_out,
  output logic                         iside_read_pulse_out,
  output logic                         iside_tag_write_pulse_out,
  output logic [`SPR_WORD_W-1:0]       iside_write_compare_bus_out,
  output logic                         iside_data_write_pulse_out,
  input  wire logic [`SPR_WORD_W-1:0]  iside_read_word_in,
  input  wire logic [`SPR_TAG_W-1:0]   iside_tag_read_word_in,
  input  wire logic                    iside_region_match_in,
  input  wire logic                    iside_wait_req_in,
  input  wire logic                    iside_array_attached_in,
  // Data-side memory pins.
  output logic [`SPR_IDX_W-3:0]        dside_tag_index_out,
  output logic                         dside_tag_read_pulse_out,
  output logic                         dside_tag_write_pulse_out,
  output logic [`SPR_TAG_W-1:0]        dside_tag_compare_word_out,
  output logic [`SPR_IDX_W-1:0]        dside_data_index_out,
  output logic [`SPR_WORD_W-1:0]       dside_write_word_out,
  output logic                         dside_data_read_pulse_out,
  output logic                         dside_data_write_pulse_out,
  output logic [`SPR_BE_W-1:0]         dside_byte_enables_out,
  input  wire logic [`SPR_WORD_W-1:0]  dside_read_word_in,
  input  wire logic [`SPR_TAG_W-1:0]   dside_tag_read_word_in,
  input  wire logic                    dside_region_match_in,
  input  wire logic                    dside_wait_req_in,
  input  wire logic                    dside_array_attached_in
);
  ////////////////////////////////////////////////////////////////////////////
  // Per-side views of ports; index 0 is the instruction side.
  spr_req_t                req_a     [2];
  logic                    present_a [2];
  logic                    stall_a   [2];
  logic                    hit_a     [2];
  logic [`SPR_WORD_W-1:0]  rword_a   [2];
  logic [`SPR_TAG_W-1:0]   tword_a   [2];
  spr_drv_t                drv_a     [2];
  logic                    ready_a   [2];
  logic [`SPR_TAG_W-1:0]   hold_a    [2];
  spr_rsp_t                rsp_a     [2];

  // Present is a static strap; the far side ties it.
  assign present_a[0] = iside_array_attached_in;
  assign present_a[1] = dside_array_attached_in;
  assign req_a[0]     = iside_req_in;
  assign req_a[1]     = dside_req_in;
  assign stall_a[0]   = iside_wait_req_in;
  assign stall_a[1]   = dside_wait_req_in;
  assign hit_a[0]     = iside_region_match_in;
  assign hit_a[1]     = dside_region_match_in;
  assign rword_a[0]   = iside_read_word_in;
  assign rword_a[1]   = dside_read_word_in;
  assign tword_a[0]   = iside_tag_read_word_in;
  assign tword_a[1]   = dside_tag_read_word_in;

  ////////////////////////////////////////////////////////////////////////////
  // One sequencer per side; they differ in word layout and in whether a tag read also reads data.
  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : g_side
      localparam bit IS_ISIDE = (g == 0);
      spr_state_t             state;
      spr_state_t             next_state;
      spr_drv_t               drv;
      spr_drv_t               next_drv;
      logic                   ready;
      logic                   next_ready;
      logic [`SPR_TAG_W-1:0]  hold;
      logic [`SPR_TAG_W-1:0]  next_hold;
      logic                   ack;
      logic                   complete;
      logic [`SPR_TAG_W-1:0]  cmp;
      logic                   pending_tag_op;
      logic                   next_pending_tag_op;

      // Next-state and drive computation. Strobes are outputs of flops, so
      // the memory sees them one cycle after the request is taken; its
      // answer must still settle within that cycle.
      always_comb begin
        next_state      = state;
        next_drv        = drv;
        next_drv.tag_wr = 1'h0;
        next_drv.data_wr = 1'h0;
        next_hold       = hold;
        ack             = 1'h0;
        if (IS_ISIDE) begin
          cmp = {req_a[g].pa, req_a[g].uncached, `SPR_LOW1};
        end else begin
          cmp = {req_a[g].pa, `SPR_LOW2};
        end
        unique case (state)
          ST_IDLE: begin
            if (req_a[g].valid && ready) begin
              next_drv.index = req_a[g].index;
              unique case (req_a[g].op)
                OP_LOOKUP: begin
                  next_drv.rd_tag  = present_a[g];
                  next_drv.rd_data = present_a[g];
                  next_drv.tagword = cmp;
                  if (IS_ISIDE) begin
                    next_drv.word = {`SPR_PAD8, cmp};
                  end
                  next_state = ST_READ;
                end
                OP_TAG_READ: begin
                  next_drv.rd_tag  = present_a[g];
                  next_drv.rd_data = 1'h0;
                  next_drv.tagword = cmp;
                  if (IS_ISIDE) begin
                    next_drv.rd_data = present_a[g];
                    next_drv.word    = {`SPR_PAD8, cmp};
                  end
                  next_state = ST_READ;
                end
                OP_TAG_WRITE: begin
                  next_drv.tag_wr  = present_a[g];
                  next_drv.tagword = hold;
                  if (IS_ISIDE) begin
                    next_drv.word = {`SPR_PAD8, hold};
                  end
                  ack = 1'h1;
                end
                OP_DATA_WRITE: begin
                  next_drv.data_wr = present_a[g];
                  next_drv.word    = req_a[g].wdata;
                  next_drv.be      = req_a[g].be;
                  ack = 1'h1;
                end
                OP_TAG_SET: begin
                  next_hold = req_a[g].wdata[`SPR_TAG_W-1:0];
                  ack = 1'h1;
                end
                default: begin
                  ack = 1'h1;
                end
              endcase
            end
          end
          ST_READ: begin
            // Everything the memory sees stays put until stall drops.
            if (complete) begin
              next_drv.rd_tag  = 1'h0;
              next_drv.rd_data = 1'h0;
              next_state       = ST_IDLE;
              if (present_a[g] && (drv.rd_data == 1'h0 || IS_ISIDE) &&
                  drv.rd_tag && pending_tag_op) begin
                next_hold = tword_a[g];
              end
            end
          end
        endcase
        next_ready = (next_state == ST_IDLE);
      end

      // Remembers that the pending read is a cache-maintenance tag read.
      always_comb begin
        next_pending_tag_op = pending_tag_op;
        if (state == ST_IDLE && req_a[g].valid && ready) begin
          next_pending_tag_op = (req_a[g].op == OP_TAG_READ);
        end
      end

      // State registers.
      always_ff @(posedge ref_clk_in) begin
        if (reset_in) begin
          state          <= ST_IDLE;
          ready          <= 1'h0;
          hold           <= `SPR_TAG_RST;
          pending_tag_op <= 1'h0;
          drv            <= '{rd_tag: 1'h0, rd_data: 1'h0, tag_wr: 1'h0,
                              data_wr: 1'h0, index: `SPR_IDX_RST,
                              word: `SPR_WORD_RST, tagword: `SPR_TAG_RST,
                              be: `SPR_BE_RST};
        end else begin
          state          <= next_state;
          ready          <= next_ready;
          hold           <= next_hold;
          pending_tag_op <= next_pending_tag_op;
          drv            <= next_drv;
        end
      end

      // A read with no array attached still passes through ST_READ so the
      // answer timing is the same; it completes at once as a miss.
      spr_resp u_resp (
        .ref_clk_in   (ref_clk_in),
        .reset_in     (reset_in),
        .rd_active_in (state == ST_READ),
        .ack_in       (ack),
        .present_in   (present_a[g]),
        .stall_in     (stall_a[g]),
        .hit_in       (hit_a[g]),
        .read_word_in (rword_a[g]),
        .tag_word_in  (tword_a[g]),
        .complete_out (complete),
        .rsp_out      (rsp_a[g])
      );

      assign drv_a[g]   = drv;
      assign ready_a[g] = ready;
      assign hold_a[g]  = hold;
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Pins; no logic between the flops and the boundary.
  assign iside_index_out                = drv_a[0].index;
  assign iside_read_pulse_out           = drv_a[0].rd_tag;
  assign iside_tag_write_pulse_out      = drv_a[0].tag_wr;
  assign iside_write_compare_bus_out    = drv_a[0].word;
  assign iside_data_write_pulse_out     = drv_a[0].data_wr;
  assign dside_tag_index_out            =
    drv_a[1].index[`SPR_IDX_W-1:`SPR_TIDX_LSB];
  assign dside_tag_read_pulse_out       = drv_a[1].rd_tag;
  assign dside_tag_write_pulse_out      = drv_a[1].tag_wr;
  assign dside_tag_compare_word_out     = drv_a[1].tagword;
  assign dside_data_index_out           = drv_a[1].index;
  assign dside_write_word_out           = drv_a[1].word;
  assign dside_data_read_pulse_out      = drv_a[1].rd_data;
  assign dside_data_write_pulse_out     = drv_a[1].data_wr;
  assign dside_byte_enables_out         = drv_a[1].be;
  assign iside_ready_out                = ready_a[0];
  assign dside_ready_out                = ready_a[1];
  assign iside_rsp_out                  = rsp_a[0];
  assign dside_rsp_out                  = rsp_a[1];
  assign iside_tag_holding_register_out = hold_a[0];
  assign dside_tag_holding_register_out = hold_a[1];
endmodule
`default_nettype wire

// File: core/spr_resp.sv
// Response capture for one scratchpad port.
`timescale 1ns/1ns
`default_nettype none
`include "spr_cfg.svh"
module spr_resp
  import spr_pkg::*;
(
  input  wire logic                   ref_clk_in,
  input  wire logic                   reset_in,
  input  wire logic                   rd_active_in,
  input  wire logic                   ack_in,
  input  wire logic                   present_in,
  input  wire logic                   stall_in,
  input  wire logic                   hit_in,
  input  wire logic [`SPR_WORD_W-1:0] read_word_in,
  input  wire logic [`SPR_TAG_W-1:0]  tag_word_in,
  output logic                        complete_out,
  output spr_rsp_t                    rsp_out
);
  spr_rsp_t next_rsp;
  logic     take;

  // A read ends when the memory drops stall, or at once when no array.
  always_comb begin
    complete_out = rd_active_in && (!present_in || !stall_in);
    take         = complete_out && present_in;
    next_rsp      = rsp_out;
    next_rsp.done = complete_out || ack_in;
    next_rsp.hit  = take && hit_in;
    if (take) begin
      next_rsp.data = read_word_in;
      next_rsp.tag  = tag_word_in;
    end
  end

  // Result flops; data and tag hold until the next read completed with an array present.
  always_ff @(posedge ref_clk_in) begin
    if (reset_in) begin
      rsp_out <= '{done: 1'h0, hit: 1'h0, data: `SPR_WORD_RST,
                   tag: `SPR_TAG_RST};
    end else begin
      rsp_out <= next_rsp;
    end
  end
endmodule
`default_nettype wire

// File: pkg/spr_cfg.svh
// Widths, pad values and reset values of the scratchpad port.
`ifndef SPR_CFG_SVH
`define SPR_CFG_SVH
`define SPR_IDX_W      18
`define SPR_TIDX_LSB   2
`define SPR_PA_W       22
`define SPR_TAG_W      24
`define SPR_WORD_W     32
`define SPR_BE_W       4
`define SPR_OP_W       3
`define SPR_PAD8       8'h00
`define SPR_LOW2       2'h0
`define SPR_LOW1       1'h0
`define SPR_WORD_RST   32'h0000_0000
`define SPR_TAG_RST    24'h00_0000
`define SPR_IDX_RST    18'h0_0000
`define SPR_BE_RST     4'h0
`endif

// File: pkg/spr_pkg.sv
// Types shared by the scratchpad port core logic.
`include "spr_cfg.svh"
package spr_pkg;
  typedef enum logic [`SPR_OP_W-1:0] {
    OP_LOOKUP     = 3'h0,
    OP_TAG_READ   = 3'h1,
    OP_TAG_WRITE  = 3'h2,
    OP_DATA_WRITE = 3'h3,
    OP_TAG_SET    = 3'h4
  } spr_op_t;

  typedef enum logic {
    ST_IDLE = 1'h0,
    ST_READ = 1'h1
  } spr_state_t;

  typedef struct packed {
    logic                    valid;
    spr_op_t                 op;
    logic [`SPR_IDX_W-1:0]   index;
    logic [`SPR_PA_W-1:0]    pa;
    logic                    uncached;
    logic [`SPR_WORD_W-1:0]  wdata;
    logic [`SPR_BE_W-1:0]    be;
  } spr_req_t;

  typedef struct packed {
    logic                    done;
    logic                    hit;
    logic [`SPR_WORD_W-1:0]  data;
    logic [`SPR_TAG_W-1:0]   tag;
  } spr_rsp_t;

  typedef struct packed {
    logic                    rd_tag;
    logic                    rd_data;
    logic                    tag_wr;
    logic                    data_wr;
    logic [`SPR_IDX_W-1:0]   index;
    logic [`SPR_WORD_W-1:0]  word;
    logic [`SPR_TAG_W-1:0]   tagword;
    logic [`SPR_BE_W-1:0]    be;
  } spr_drv_t;
endpackage

// File: tb/scratchpad_ram_port_test.sv
// Directed bench for the scratchpad port, both sides.
`timescale 1ns/1ns
`default_nettype none
module scratchpad_ram_port_test;
  import spr_pkg::*;
  localparam logic [21:0] PA = 22'h12_3456;
  localparam logic [23:0] TG = {PA, 2'b01};
  logic ref_clk_in = 1'b0, reset_in = 1'b1;
  spr_req_t iside_req_in = '0, dside_req_in = '0;
  spr_rsp_t iside_rsp_out, dside_rsp_out, rsp;
  logic iside_ready_out, dside_ready_out, iside_region_match_in;
  logic iside_wait_req_in, dside_region_match_in, dside_wait_req_in;
  logic iside_read_pulse_out, iside_tag_write_pulse_out;
  logic iside_data_write_pulse_out, dside_tag_read_pulse_out;
  logic dside_tag_write_pulse_out, dside_data_read_pulse_out;
  logic dside_data_write_pulse_out;
  logic iside_array_attached_in = 1'b1, dside_array_attached_in = 1'b1;
  logic [23:0] iside_tag_holding_register_out, dside_tag_holding_register_out;
  logic [23:0] iside_tag_read_word_in, dside_tag_read_word_in;
  logic [23:0] dside_tag_compare_word_out;
  logic [17:0] iside_index_out, dside_data_index_out;
  logic [15:0] dside_tag_index_out;
  logic [31:0] iside_write_compare_bus_out, iside_read_word_in;
  logic [31:0] dside_read_word_in, dside_write_word_out;
  logic [3:0]  dside_byte_enables_out;
  int          miscompares = 0, checks_done = 0, cycles = 0;

  spr_port DUT (.*);
  // The instruction side is slow to answer, the data side prompt-ish.
  spr_mem_model #(.STALL(3)) u_imem (.clk_in(ref_clk_in),
    .rd_in(iside_read_pulse_out), .data_wr_in(iside_data_write_pulse_out),
    .tag_wr_in(iside_tag_write_pulse_out), .index_in(iside_index_out),
    .wdata_in(iside_write_compare_bus_out), .be_in(4'hF),
    .tag_word_in(iside_write_compare_bus_out[23:0]),
    .read_word_out(iside_read_word_in), .tag_word_out(iside_tag_read_word_in),
    .hit_out(iside_region_match_in), .wait_out(iside_wait_req_in));
  spr_mem_model #(.STALL(1)) u_dmem (.clk_in(ref_clk_in),
    .rd_in(dside_tag_read_pulse_out | dside_data_read_pulse_out),
    .data_wr_in(dside_data_write_pulse_out),
    .tag_wr_in(dside_tag_write_pulse_out), .index_in(dside_data_index_out),
    .wdata_in(dside_write_word_out), .be_in(dside_byte_enables_out),
    .tag_word_in(dside_tag_compare_word_out),
    .read_word_out(dside_read_word_in), .tag_word_out(dside_tag_read_word_in),
    .hit_out(dside_region_match_in), .wait_out(dside_wait_req_in));

  ////////////////////////////////////////////////////////////////////////
  // Clock and a cycle ceiling that cuts a hang short.
  always #20 ref_clk_in = ~ref_clk_in;
  always @(posedge ref_clk_in) begin
    cycles++;
    if (cycles == 2000) begin
      miscompares++;
      summarize();
    end
  end

  // Compare one value and count it.
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      miscompares++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic summarize();
    if (miscompares == 0 && checks_done > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  function automatic logic [31:0] hold(input logic s);
    return {8'h00, s ? dside_tag_holding_register_out
                     : iside_tag_holding_register_out};
  endfunction

  // Valid stays up until an edge sees ready, then the answer is awaited.
  task automatic xfer(input logic s, input spr_op_t op, input logic [17:0] ix,
                      input logic [21:0] pa, input logic un,
                      input logic [31:0] wd, input logic [3:0] be);
    spr_req_t q;
    int       n;
    q = '{valid: 1'b1, op: op, index: ix, pa: pa, uncached: un,
          wdata: wd, be: be};
    if (s) dside_req_in <= q; else iside_req_in <= q;
    n = 0;
    do begin @(posedge ref_clk_in); n++; end
    while ((s ? dside_ready_out : iside_ready_out) !== 1'b1 && n < 20);
    q.valid = 1'b0;
    if (s) dside_req_in <= q; else iside_req_in <= q;
    do begin @(posedge ref_clk_in); n++; end
    while ((s ? dside_rsp_out.done : iside_rsp_out.done) !== 1'b1 && n < 40);
    rsp = s ? dside_rsp_out : iside_rsp_out;
    if (n >= 40) chk(32'h0000_0000, 32'h0000_0001);
  endtask

  ////////////////////////////////////////////////////////////////////////
  // Main sequence: tag setup, writes merged on the data side only, hit and miss, tag read-back.
  initial begin
    repeat (3) @(posedge ref_clk_in);
    chk({28'h000_0000, iside_read_pulse_out, iside_data_write_pulse_out,
         iside_ready_out, iside_rsp_out.done}, 32'h0000_0000);
    reset_in <= 1'b0;
    @(posedge ref_clk_in);
    for (int s = 0; s < 2; s++) begin
      xfer(s[0], OP_TAG_SET, 18'h0_0000, PA, 1'b0, {8'h00, TG}, 4'h0);
      xfer(s[0], OP_TAG_WRITE, 18'h0_0005, PA, 1'b0, 32'h0, 4'h0);
      xfer(s[0], OP_DATA_WRITE, 18'h0_0005, PA, 1'b0, 32'hCAFE_F00D, 4'hF);
      xfer(s[0], OP_DATA_WRITE, 18'h0_0005, PA, 1'b0, 32'h1234_5678, 4'h3);
      xfer(s[0], OP_LOOKUP, 18'h0_0005, PA, 1'b0, 32'h0, 4'h0);
      chk({31'h0, rsp.hit}, 32'h0000_0001);
      chk(rsp.data, s ? 32'hCAFE_5678 : 32'h1234_5678);
      chk({8'h00, rsp.tag}, {8'h00, TG});
      xfer(s[0], OP_LOOKUP, 18'h0_0005, PA ^ 22'h00_0001, 1'b1, 32'h0, 4'h0);
      chk({31'h0, rsp.hit}, 32'h0000_0000);
      xfer(s[0], OP_TAG_SET, 18'h0_0000, PA, 1'b0, 32'h0, 4'h0);
      xfer(s[0], OP_TAG_READ, 18'h0_0005, PA, 1'b0, 32'h0, 4'h0);
      chk(hold(s[0]), {8'h00, TG});
      xfer(s[0], spr_op_t'(3'h5), 18'h0_0005, PA, 1'b0, 32'h0, 4'h0);
    end
    // The data-side tag index is the word index without its low bits.
    chk({16'h0000, dside_tag_index_out}, 32'h0000_0001);
    // Unpopulated port: the lookup must miss and keep the old data.
    iside_array_attached_in <= 1'b0;
    xfer(1'b0, OP_LOOKUP, 18'h0_0005, PA, 1'b0, 32'h0, 4'h0);
    chk({31'h0, rsp.hit}, 32'h0000_0000);
    chk(rsp.data, 32'h1234_5678);
    summarize();
  end
endmodule
`default_nettype wire

// File: tb/spr_mem_model.sv
// Behavioural scratchpad array with its tag logic, one port.
`timescale 1ns/1ns
`default_nettype none
module spr_mem_model #(
  parameter int STALL = 0
) (
  input  wire logic        clk_in,
  input  wire logic        rd_in,
  input  wire logic        data_wr_in,
  input  wire logic        tag_wr_in,
  input  wire logic [17:0] index_in,
  input  wire logic [31:0] wdata_in,
  input  wire logic [3:0]  be_in,
  input  wire logic [23:0] tag_word_in,
  output logic      [31:0] read_word_out,
  output logic      [23:0] tag_word_out,
  output logic             hit_out,
  output logic             wait_out
);
  logic [31:0] mem [16];
  logic [23:0] tag_q  = 24'h00_0000;
  logic [31:0] last_q = 32'h0000_0000;
  int          cnt    = 0;

  initial foreach (mem[i]) mem[i] = 32'h0000_0000;

  // Stores land on the edge; the stall count restarts with every strobe.
  always @(posedge clk_in) begin
    cnt <= rd_in ? cnt + 1 : 0;
    if (tag_wr_in) tag_q <= tag_word_in;
    if (rd_in) last_q <= read_word_out;
    for (int b = 0; b < 4; b++) begin
      if (data_wr_in && be_in[b]) begin
        mem[index_in[3:0]][8*b +: 8] <= wdata_in[8*b +: 8];
      end
    end
  end

  // Answers settle in the strobe's cycle; off the strobe the word lines float,
  // so they show the inverse of the last value, never a stale copy.
  assign wait_out = rd_in && (cnt < STALL);
  assign hit_out = rd_in && tag_q[0] &&
                   (tag_q[23:2] == tag_word_in[23:2]);
  assign read_word_out = rd_in ? mem[index_in[3:0]] : ~last_q;
  assign tag_word_out = rd_in ? tag_q : ~tag_q;
endmodule
`default_nettype wire

// File: tb/spr_port_assertions.sv
// Concurrent checks on the boundary of the scratchpad port.
`timescale 1ns/1ns
`default_nettype none
`include "spr_cfg.svh"
module spr_port_assertions
  import spr_pkg::*;
(
  input wire logic                   ref_clk_in,
  input wire logic                   reset_in,
  input wire spr_req_t               iside_req_in,
  input wire spr_req_t               dside_req_in,
  input wire logic                   iside_ready_out,
  input wire logic                   dside_ready_out,
  input wire spr_rsp_t               iside_rsp_out,
  input wire logic [`SPR_TAG_W-1:0]  iside_tag_holding_register_out,
  input wire logic [`SPR_IDX_W-1:0]  iside_index_out,
  input wire logic                   iside_read_pulse_out,
  input wire logic                   iside_tag_write_pulse_out,
  input wire logic [`SPR_WORD_W-1:0] iside_write_compare_bus_out,
  input wire logic                   iside_data_write_pulse_out,
  input wire logic [`SPR_WORD_W-1:0] iside_read_word_in,
  input wire logic                   iside_wait_req_in,
  input wire logic                   iside_array_attached_in,
  input wire logic                   dside_tag_read_pulse_out,
  input wire logic [`SPR_TAG_W-1:0]  dside_tag_compare_word_out,
  input wire logic                   dside_data_write_pulse_out,
  input wire logic [`SPR_WORD_W-1:0] dside_write_word_out,
  input wire logic [`SPR_BE_W-1:0]   dside_byte_enables_out,
  input wire logic                   dside_array_attached_in
);
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (reset_in);

  ////////////////////////////////////////////////////////////////////////
  // A request taken on a populated port; an empty port takes no strobes.
  wire logic i_take = iside_req_in.valid && iside_ready_out &&
                      iside_array_attached_in;
  wire logic d_take = dside_req_in.valid && dside_ready_out &&
                      dside_array_attached_in;

  lookup_index_a: assert property (
    i_take && iside_req_in.op == OP_LOOKUP |=> iside_read_pulse_out &&
    iside_index_out == $past(iside_req_in.index) &&
    iside_write_compare_bus_out == {8'h00, $past(iside_req_in.pa),
    $past(iside_req_in.uncached), 1'b0})
    else $error("lookup index or compare word wrong");
  stall_hold_a: assert property (
    iside_read_pulse_out && iside_wait_req_in |=> iside_read_pulse_out &&
    !iside_rsp_out.done && $stable(iside_index_out) &&
    $stable(iside_write_compare_bus_out))
    else $error("stalled read not held");
  read_done_a: assert property (
    iside_read_pulse_out && !iside_wait_req_in |=> iside_rsp_out.done &&
    !iside_read_pulse_out && iside_rsp_out.data == $past(iside_read_word_in))
    else $error("read not completed with memory word");
  tag_bus_a: assert property (
    iside_tag_write_pulse_out |-> iside_write_compare_bus_out ==
    {8'h00, iside_tag_holding_register_out})
    else $error("tag write bus wrong");
  data_write_a: assert property (
    i_take && iside_req_in.op == OP_DATA_WRITE |=> iside_data_write_pulse_out
    && iside_write_compare_bus_out == $past(iside_req_in.wdata) &&
    iside_index_out == $past(iside_req_in.index))
    else $error("data write wrong");
  dside_be_a: assert property (
    d_take && dside_req_in.op == OP_DATA_WRITE |=> dside_data_write_pulse_out
    && dside_byte_enables_out == $past(dside_req_in.be) &&
    dside_write_word_out == $past(dside_req_in.wdata))
    else $error("byte enables wrong");
  dside_cmp_a: assert property (
    d_take && dside_req_in.op == OP_LOOKUP |=> dside_tag_read_pulse_out &&
    dside_tag_compare_word_out == {$past(dside_req_in.pa), 2'b00})
    else $error("data side compare word wrong");
  absent_quiet_a: assert property (
    !iside_array_attached_in && !$past(iside_array_attached_in) |->
    !(iside_read_pulse_out || iside_tag_write_pulse_out ||
    iside_data_write_pulse_out))
    else $error("strobe on empty port");

  // Main scenarios reached.
  cover property (iside_read_pulse_out && iside_wait_req_in);
  cover property (iside_tag_write_pulse_out);
  cover property (dside_data_write_pulse_out);
endmodule
bind spr_port spr_port_assertions u_chk (.*);
`default_nettype wire
